// file: include/pmdp_pkg.sv
// Purpose: Shared constants and types of the MAC-facing data port.
// Assumes: Core clock of 25 MHz; the half-period counts derive from it.
// Notes:   Counts round toward the shorter side, never below one.
package pmdp_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Clock rates
   localparam int CLOCK_HZ      = 25_000_000;
   localparam int MII_10M_HZ    = 2_500_000;
   localparam int MII_100M_HZ   = 25_000_000;
   localparam int RMII_REF_HZ   = 50_000_000;
   localparam int RATE_10M_BPS  = 10_000_000;

   // Half periods of the generated nibble clock, in core cycles
   localparam int HALF_W        = 4;
   localparam int HALF_10M_INT  = CLOCK_HZ / (2 * MII_10M_HZ);
   localparam int HALF_100M_RAW = CLOCK_HZ / (2 * MII_100M_HZ);
   localparam int HALF_100M_INT = (HALF_100M_RAW < 1) ? 1 : HALF_100M_RAW;
   localparam logic [HALF_W-1:0] HALF_10M  = HALF_W'(HALF_10M_INT);
   localparam logic [HALF_W-1:0] HALF_100M = HALF_W'(HALF_100M_INT);

   // Reference edges per di-bit at 10 Mb/s
   localparam int REP_W         = 4;
   localparam int RMII_10M_REP  = RMII_REF_HZ / (RATE_10M_BPS / 2);
   localparam logic [REP_W-1:0] REP_10M_LAST = REP_W'(RMII_10M_REP - 1);
   localparam logic [REP_W-1:0] REP_ZERO     = 4'h0;

   ////////////////////////////////////////////////////////////////////////
   // Idle codes
   localparam logic [1:0] IDLE_DIBIT  = 2'h0;
   localparam logic [3:0] IDLE_NIBBLE = 4'h0;

   // Bit positions in the synchroniser bank
   localparam int SY_REF  = 0;
   localparam int SY_LCLK = 1;
   localparam int SY_TXEN = 2;
   localparam int SY_TXD  = 3;
   localparam int SY_N    = 7;

   typedef enum logic [1:0] {
      RX_IDLE    = 2'b00,
      RX_CARRIER = 2'b01,
      RX_FRAME   = 2'b10,
      RX_DRAIN   = 2'b11
   } pmdp_rx_e;

endpackage

// file: include/pmdp_sync_if.sv
// Purpose: Raw inputs and their synchronised levels and edges.
// Assumes: One synchroniser bank per user.
// Notes:   Edges are one-cycle pulses on the core clock.
`timescale 1ns/1ps
interface pmdp_sync_if #(parameter int N = 1);
   logic [N-1:0] raw;
   logic [N-1:0] level;
   logic [N-1:0] rise;
   logic [N-1:0] fall;
   modport sync (input raw, output level, output rise, output fall);
   modport user (output raw, input level, input rise, input fall);
endinterface

// file: verilog/pmdp_sync.sv
// Purpose: Two-flop synchroniser bank with edge detection.
// Assumes: Inputs may change at any time.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
module pmdp_sync #(parameter int N = 1)
(
   input  wire logic i_clock,
   input  wire logic i_reset_n,
   pmdp_sync_if.sync sy
);
   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
      logic [N-1:0] s3;
   } pmdp_sync_state_s;

   pmdp_sync_state_s st;
   pmdp_sync_state_s next_st;

   always_comb
   begin
      next_st    = st;
      next_st.s1 = sy.raw;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
   end

   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         st <= '0;
      else
         st <= next_st;
   end

   assign sy.level = st.s2;
   assign sy.rise  = st.s2 & ~st.s3;
   assign sy.fall  = ~st.s2 & st.s3;
endmodule

// file: verilog/pmdp_clkgen.sv
// Purpose: Free-running divided clock with falling-edge pulses.
// Assumes: Half period given in core cycles, at least one.
// Notes:   A change of half period takes effect at the next toggle.
`timescale 1ns/1ps
module pmdp_clkgen
   import pmdp_pkg::*;
(
   input  wire logic                        i_clock,
   input  wire logic                        i_reset_n,
   input  wire logic [pmdp_pkg::HALF_W-1:0] i_half,
   output logic                             o_clock,
   output logic                             o_fall
);
   typedef struct packed {
      logic [HALF_W-1:0] cnt;
      logic              clk;
      logic              fall;
   } pmdp_clkgen_state_s;

   pmdp_clkgen_state_s st;
   pmdp_clkgen_state_s next_st;

   always_comb
   begin
      next_st      = st;
      next_st.fall = 1'b0;
      if (st.cnt == '0)
      begin
         next_st.cnt  = HALF_W'(i_half - 1'b1);
         next_st.clk  = ~st.clk;
         next_st.fall = st.clk;
      end
      else
      begin
         next_st.cnt = HALF_W'(st.cnt - 1'b1);
      end
   end

   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         st <= '0;
      else
         st <= next_st;
   end

   assign o_clock = st.clk;
   assign o_fall  = st.fall;
endmodule

// file: verilog/pmdp_port.sv
// Purpose: PHY data port toward a MAC, nibble or reduced di-bit form.
// Assumes: Line-side inputs share the core clock; pins and the
//          recovered line clock do not and are synchronised.
// Notes:   Form, speed, duplex and link are static during a frame.
`timescale 1ns/1ps
module pmdp_port
   import pmdp_pkg::*;
(
   input  wire logic       i_clock,
   input  wire logic       i_reset_n,
   input  wire logic       i_rmii_mode,
   input  wire logic       i_speed_100,
   input  wire logic       i_full_duplex,
   input  wire logic       i_link_up,
   output logic            o_mii_tx_clock,
   input  wire logic       i_mii_tx_enable,
   input  wire logic [3:0] i_mii_tx_data,
   output logic            o_mii_rx_clock,
   output logic            o_mii_rx_valid,
   output logic [3:0]      o_mii_rx_data,
   output logic            o_mii_rx_error,
   output logic            o_mii_carrier,
   output logic            o_mii_collision,
   input  wire logic       i_reference_clock_input,
   input  wire logic       i_rmii_tx_enable,
   input  wire logic [1:0] i_rmii_tx_data,
   output logic            o_rmii_crs_dv,
   output logic [1:0]      o_rmii_rx_data,
   output logic            o_rmii_rx_error,
   input  wire logic       i_line_rx_clock,
   input  wire logic [3:0] i_line_nibble,
   input  wire logic       i_line_nibble_valid,
   input  wire logic       i_line_sfd,
   input  wire logic       i_line_code_error,
   input  wire logic       i_line_preamble_ok,
   input  wire logic       i_line_start_pair,
   input  wire logic       i_line_end_pair,
   input  wire logic       i_line_eof,
   input  wire logic       i_line_idle,
   input  wire logic       i_line_squelch,
   input  wire logic       i_line_zero_pair,
   input  wire logic       i_line_false_carrier,
   output logic [3:0]      o_line_tx_nibble,
   output logic            o_line_tx_valid,
   output logic            o_line_tx_active
);

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      pmdp_rx_e          rx_st;
      logic              crs;
      logic              col;
      logic              tx_act;
      logic [1:0]        tx_dly;
      logic [3:0]        tx_nib;
      logic              tx_vld;
      logic              tx_ph;
      logic [1:0]        tx_asm;
      logic [REP_W-1:0]  tx_rep;
      logic              rx_clk;
      logic [3:0]        hold;
      logic              hold_vld;
      logic              sfd_seen;
      logic              false_car;
      logic              err_pend;
      logic [3:0]        rxd;
      logic              rxdv;
      logic              rxer;
      logic [3:0]        sh;
      logic              ph;
      logic [REP_W-1:0]  rx_rep;
      logic              crs_dv;
      logic [1:0]        rmii_rxd;
      logic              rmii_rxer;
   } pmdp_state_s;

   pmdp_state_s st;
   pmdp_state_s next_st;

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers and nibble clock

   pmdp_sync_if #(.N(SY_N)) sy_if ();

   logic              gen_clk;
   logic              gen_fall;
   logic [HALF_W-1:0] half_sel;

   // Pins of the unused form are never looked at
   assign sy_if.raw[SY_REF]  = i_reference_clock_input;
   assign sy_if.raw[SY_LCLK] = i_line_rx_clock;
   assign sy_if.raw[SY_TXEN] = i_rmii_mode ? i_rmii_tx_enable
                                           : i_mii_tx_enable;
   assign sy_if.raw[SY_TXD+3:SY_TXD] = i_rmii_mode
                                     ? {2'h0, i_rmii_tx_data}
                                     : i_mii_tx_data;

   pmdp_sync #(.N(SY_N)) u_sync
   (
      .i_clock   (i_clock),
      .i_reset_n (i_reset_n),
      .sy        (sy_if.sync)
   );

   assign half_sel = i_speed_100 ? HALF_100M : HALF_10M;

   pmdp_clkgen u_clkgen
   (
      .i_clock   (i_clock),
      .i_reset_n (i_reset_n),
      .i_half    (half_sel),
      .o_clock   (gen_clk),
      .o_fall    (gen_fall)
   );

   ////////////////////////////////////////////////////////////////////////
   // Decoded events

   logic       tx_en_s;
   logic [3:0] txd_s;
   logic       ref_tick;
   logic       lclk_s;
   logic       set_ev;
   logic       clr_ev;
   logic       use_line;
   logic       sel_clk;
   logic       rx_fall;
   logic       accept;

   assign tx_en_s  = sy_if.level[SY_TXEN];
   assign txd_s    = sy_if.level[SY_TXD+3:SY_TXD];
   // Falling reference edge: mid-cycle, clear of the MAC's launch edge
   assign ref_tick = sy_if.fall[SY_REF];
   assign lclk_s   = sy_if.level[SY_LCLK];

   always_comb
   begin
      set_ev = 1'b0;
      clr_ev = 1'b0;
      if (i_rmii_mode && !i_speed_100)
      begin
         set_ev = i_line_squelch;
         clr_ev = !i_line_squelch;
      end
      else if (i_rmii_mode)
      begin
         set_ev = i_line_zero_pair;
         clr_ev = i_line_end_pair | i_line_idle;
      end
      else if (!i_speed_100)
      begin
         set_ev = i_line_preamble_ok;
         clr_ev = i_line_eof;
      end
      else
      begin
         set_ev = i_line_start_pair;
         clr_ev = i_line_end_pair | i_line_idle;
      end
   end

   // Receive clock source: line only while it is trustworthy
   assign use_line = i_link_up & (i_speed_100 | st.crs);
   assign sel_clk  = use_line ? lclk_s : gen_clk;
   assign rx_fall  = st.rx_clk & ~sel_clk;

   // 10M nibble form discards preamble until the delimiter
   assign accept = i_line_nibble_valid && !st.false_car
                 && (st.rx_st == RX_CARRIER || st.rx_st == RX_FRAME)
                 && (i_rmii_mode || i_speed_100
                     || st.sfd_seen || i_line_sfd);

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      next_st        = st;
      next_st.tx_vld = 1'b0;
      next_st.tx_act = tx_en_s;
      next_st.tx_dly = {st.tx_dly[0], gen_fall};

      // Transmit: data outside enable is never taken
      if (!tx_en_s)
      begin
         next_st.tx_ph  = 1'b0;
         next_st.tx_rep = REP_ZERO;
      end
      else if (!i_rmii_mode && st.tx_dly[1])
      begin
         next_st.tx_nib = txd_s;
         next_st.tx_vld = 1'b1;
      end
      else if (i_rmii_mode && ref_tick)
      begin
         if (st.tx_rep != REP_ZERO)
         begin
            next_st.tx_rep = REP_W'(st.tx_rep - 1'b1);
         end
         else
         begin
            next_st.tx_rep = i_speed_100 ? REP_ZERO : REP_10M_LAST;
            if (!st.tx_ph)
            begin
               next_st.tx_asm = txd_s[1:0];
               next_st.tx_ph  = 1'b1;
            end
            else
            begin
               next_st.tx_nib = {txd_s[1:0], st.tx_asm};
               next_st.tx_vld = 1'b1;
               next_st.tx_ph  = 1'b0;
            end
         end
      end

      // Carrier and collision; a set beats a clear
      if (set_ev)
         next_st.crs = 1'b1;
      else if (clr_ev)
         next_st.crs = 1'b0;
      next_st.col = !i_full_duplex && tx_en_s && st.crs;

      if (i_line_sfd && st.rx_st != RX_IDLE)
         next_st.sfd_seen = 1'b1;
      if (i_line_false_carrier && st.rx_st == RX_CARRIER)
         next_st.false_car = 1'b1;

      next_st.rx_clk = sel_clk;

      // Nibble form presentation on falling receive clock
      if (!i_rmii_mode && rx_fall)
      begin
         if (st.hold_vld)
         begin
            next_st.rxd      = st.hold;
            next_st.rxdv     = 1'b1;
            next_st.rxer     = st.err_pend;
            next_st.err_pend = 1'b0;
            next_st.hold_vld = 1'b0;
         end
         else
         begin
            next_st.rxd  = IDLE_NIBBLE;
            next_st.rxdv = 1'b0;
            next_st.rxer = 1'b0;
         end
      end

      // Di-bit form: valid rises at once on carrier
      if (i_rmii_mode && set_ev)
         next_st.crs_dv = 1'b1;
      if (i_rmii_mode && ref_tick)
      begin
         if (st.rx_rep != REP_ZERO)
         begin
            next_st.rx_rep = REP_W'(st.rx_rep - 1'b1);
         end
         else
         begin
            next_st.rx_rep = i_speed_100 ? REP_ZERO : REP_10M_LAST;
            if (st.ph)
            begin
               next_st.rmii_rxd  = st.sh[3:2];
               next_st.crs_dv    = 1'b1;
               next_st.rmii_rxer = 1'b0;
               next_st.ph        = 1'b0;
            end
            else if (st.hold_vld)
            begin
               next_st.sh        = st.hold;
               next_st.rmii_rxd  = st.hold[1:0];
               next_st.rmii_rxer = st.err_pend;
               next_st.err_pend  = 1'b0;
               next_st.hold_vld  = 1'b0;
               next_st.ph        = 1'b1;
               next_st.crs_dv    = next_st.crs;
            end
            else
            begin
               // No decoded data yet, or false carrier
               next_st.rmii_rxd  = IDLE_DIBIT;
               next_st.rmii_rxer = 1'b0;
               next_st.crs_dv    = next_st.crs;
            end
         end
      end

      // Error seen in a frame waits for its nibble; set wins
      if (i_line_code_error && st.rx_st != RX_IDLE)
         next_st.err_pend = 1'b1;

      // One-nibble hold; a new nibble wins over the drain
      if (accept)
      begin
         next_st.hold     = i_line_nibble;
         next_st.hold_vld = 1'b1;
      end

      case (st.rx_st)
         RX_IDLE:
         begin
            next_st.sfd_seen  = 1'b0;
            next_st.false_car = 1'b0;
            if (set_ev)
               next_st.rx_st = RX_CARRIER;
         end
         RX_CARRIER:
         begin
            if (accept)
               next_st.rx_st = RX_FRAME;
            else if (!next_st.crs)
               next_st.rx_st = RX_DRAIN;
         end
         RX_FRAME:
         begin
            if (!next_st.crs)
               next_st.rx_st = RX_DRAIN;
         end
         RX_DRAIN:
         begin
            // Idle only once every bit has left
            if (!next_st.hold_vld && !next_st.ph)
               next_st.rx_st = RX_IDLE;
         end
         default:
         begin
            next_st.rx_st = RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         st       <= '0;
         st.rx_st <= RX_IDLE;
      end
      else
      begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign o_mii_tx_clock   = gen_clk;
   assign o_mii_rx_clock   = st.rx_clk;
   assign o_mii_rx_valid   = st.rxdv;
   assign o_mii_rx_data    = st.rxd;
   assign o_mii_rx_error   = st.rxer;
   assign o_mii_carrier    = st.crs;
   assign o_mii_collision  = st.col;
   assign o_rmii_crs_dv    = st.crs_dv;
   assign o_rmii_rx_data   = st.rmii_rxd;
   assign o_rmii_rx_error  = st.rmii_rxer;
   assign o_line_tx_nibble = st.tx_nib;
   assign o_line_tx_valid  = st.tx_vld;
   assign o_line_tx_active = st.tx_act;
endmodule

// file: tb/pmdp_port_assertions.sv
// Purpose: Port-level checks of the MAC-facing data port.
// Assumes: One core clock domain, async active-low reset.
// Notes:   Bound to every instance of the port.
`timescale 1ns/1ps
module pmdp_port_assertions
(
   input wire logic       i_clock,
   input wire logic       i_reset_n,
   input wire logic       i_rmii_mode,
   input wire logic       i_speed_100,
   input wire logic       i_full_duplex,
   input wire logic       o_mii_tx_clock,
   input wire logic       o_mii_rx_valid,
   input wire logic [3:0] o_mii_rx_data,
   input wire logic       o_mii_carrier,
   input wire logic       o_mii_collision,
   input wire logic       o_rmii_crs_dv,
   input wire logic [1:0] o_rmii_rx_data,
   input wire logic       i_line_start_pair,
   input wire logic       i_line_end_pair,
   input wire logic       i_line_zero_pair,
   input wire logic       o_line_tx_valid,
   input wire logic       o_line_tx_active
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_reset_n);
   ////////////////////////////////////////////////////////////////////////
   // High phase of the slow nibble clock: five core cycles
   sequence s_high5;
      o_mii_tx_clock [*5] ##1 !o_mii_tx_clock;
   endsequence
   AST_TXCLK_10M: assert property ($rose(o_mii_tx_clock) && !i_speed_100 |-> s_high5)
      else $error("tx clock high time wrong");
   AST_TXCLK_100M: assert property (i_speed_100 [*3] |-> $changed(o_mii_tx_clock))
      else $error("tx clock stalled");
   AST_MII_IDLE: assert property (!o_mii_rx_valid |-> o_mii_rx_data == 4'h0)
      else $error("rx data not idle");
   AST_RMII_CRS_UP: assert property (i_rmii_mode && i_speed_100 && i_line_zero_pair && !o_rmii_crs_dv && o_rmii_rx_data == 2'h0 |=> o_rmii_crs_dv && o_rmii_rx_data == 2'h0)
      else $error("combined valid not raised");
   AST_COL_ON: assert property ((o_line_tx_active && o_mii_carrier && !i_full_duplex) [*3] |-> o_mii_collision)
      else $error("collision missing");
   AST_CRS_SET: assert property (!i_rmii_mode && i_speed_100 && i_line_start_pair |=> o_mii_carrier)
      else $error("carrier not raised");
   AST_CRS_CLR: assert property (!i_rmii_mode && i_speed_100 && i_line_end_pair && !i_line_start_pair |=> !o_mii_carrier)
      else $error("carrier not dropped");
   AST_TX_GATED: assert property (o_line_tx_valid |-> o_line_tx_active || $past(o_line_tx_active))
      else $error("nibble taken while idle");
endmodule
////////////////////////////////////////////////////////////////////////////
bind pmdp_port pmdp_port_assertions i_chk
(
   .i_clock, .i_reset_n, .i_rmii_mode, .i_speed_100, .i_full_duplex,
   .o_mii_tx_clock, .o_mii_rx_valid, .o_mii_rx_data, .o_mii_carrier,
   .o_mii_collision, .o_rmii_crs_dv, .o_rmii_rx_data, .i_line_start_pair,
   .i_line_end_pair, .i_line_zero_pair, .o_line_tx_valid, .o_line_tx_active
);

// file: tb/pmdp_mac_model.sv
// Purpose: MAC beside the data port: sends frames, samples receive.
// Assumes: Reference clock made here, unrelated to the core clock.
// Notes:   Junk on idle data lines only when a scenario asks.
`timescale 1ns/1ps
module pmdp_mac_model
(
   input  wire logic       i_tx_clock,
   input  wire logic       i_rx_clock,
   input  wire logic       i_rx_valid,
   input  wire logic [3:0] i_rx_data,
   input  wire logic       i_rx_error,
   input  wire logic       i_crs_dv,
   input  wire logic [1:0] i_rmii_rx_data,
   output logic            o_ref_clock,
   output logic            o_tx_enable,
   output logic [3:0]      o_tx_data,
   output logic            o_rmii_tx_enable,
   output logic [1:0]      o_rmii_tx_data
);
   logic [3:0] rxq[$];
   logic       errq[$];
   logic [1:0] dbq[$];
   initial
   begin
      o_tx_enable      = 1'b0;
      o_tx_data        = 4'h0;
      o_rmii_tx_enable = 1'b0;
      o_rmii_tx_data   = 2'h0;
      o_ref_clock      = 1'b0;
      #7;
      forever #160 o_ref_clock = ~o_ref_clock;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic mii_send(input logic [3:0] n[$], input logic junk);
      o_tx_data = junk ? 4'h9 : 4'h0;
      repeat (3) @(posedge i_tx_clock);
      foreach (n[i])
      begin
         o_tx_enable = 1'b1;
         o_tx_data   = n[i];
         @(posedge i_tx_clock);
      end
      o_tx_enable = 1'b0;
      o_tx_data   = junk ? 4'h9 : 4'h0;
   endtask
   task automatic rmii_send(input logic [1:0] n[$], input logic junk);
      o_rmii_tx_data = junk ? 2'h3 : 2'h0;
      repeat (3) @(posedge o_ref_clock);
      foreach (n[i])
      begin
         o_rmii_tx_enable = 1'b1;
         o_rmii_tx_data   = n[i];
         @(posedge o_ref_clock);
      end
      o_rmii_tx_enable = 1'b0;
      o_rmii_tx_data   = junk ? 2'h3 : 2'h0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Error is only meaningful beside a valid nibble
   always @(posedge i_rx_clock)
      if (i_rx_valid === 1'b1)
      begin
         rxq.push_back(i_rx_data);
         errq.push_back(i_rx_error);
      end
   // Falling edge: the port's update lags the reference by a few cycles
   always @(negedge o_ref_clock)
      if (i_crs_dv === 1'b1)
         dbq.push_back(i_rmii_rx_data);
endmodule

// file: tb/testbench.sv
// Purpose: Self-checking bench of the MAC-facing data port.
// Assumes: MAC model drives transmit and samples receive.
// Notes:   Line inputs change on the falling core edge.
`timescale 1ns/1ps
module testbench;
   import pmdp_pkg::*;
   logic       i_clock, i_reset_n, i_rmii_mode, i_speed_100;
   logic       i_full_duplex, i_link_up, i_line_rx_clock, col_seen;
   logic       i_line_nibble_valid, i_line_sfd, i_line_code_error;
   logic       i_line_preamble_ok, i_line_start_pair, i_line_end_pair;
   logic       i_line_eof, i_line_zero_pair, i_mii_tx_enable;
   logic       i_reference_clock_input, i_rmii_tx_enable;
   logic [3:0] i_line_nibble, i_mii_tx_data, o_mii_rx_data;
   logic [3:0] o_line_tx_nibble, txq[$];
   logic [1:0] i_rmii_tx_data, o_rmii_rx_data;
   logic       o_mii_tx_clock, o_mii_rx_clock, o_mii_rx_valid;
   logic       o_mii_rx_error, o_mii_carrier, o_mii_collision;
   logic       o_rmii_crs_dv, o_rmii_rx_error, o_line_tx_valid;
   logic       o_line_tx_active;
   int         err_total, tests_run;
   pmdp_port i_dut
   (
      .i_clock, .i_reset_n, .i_rmii_mode, .i_speed_100, .i_full_duplex,
      .i_link_up, .o_mii_tx_clock, .i_mii_tx_enable, .i_mii_tx_data,
      .o_mii_rx_clock, .o_mii_rx_valid, .o_mii_rx_data, .o_mii_rx_error,
      .o_mii_carrier, .o_mii_collision, .i_reference_clock_input,
      .i_rmii_tx_enable, .i_rmii_tx_data, .o_rmii_crs_dv, .o_rmii_rx_data,
      .o_rmii_rx_error, .i_line_rx_clock, .i_line_nibble,
      .i_line_nibble_valid, .i_line_sfd, .i_line_code_error,
      .i_line_preamble_ok, .i_line_start_pair, .i_line_end_pair,
      .i_line_eof, .i_line_idle(1'b0), .i_line_squelch(1'b0),
      .i_line_zero_pair, .i_line_false_carrier(1'b0), .o_line_tx_nibble,
      .o_line_tx_valid, .o_line_tx_active
   );
   pmdp_mac_model i_mac
   (
      .i_tx_clock(o_mii_tx_clock), .i_rx_clock(o_mii_rx_clock),
      .i_rx_valid(o_mii_rx_valid), .i_rx_data(o_mii_rx_data),
      .i_rx_error(o_mii_rx_error), .i_crs_dv(o_rmii_crs_dv),
      .i_rmii_rx_data(o_rmii_rx_data), .o_ref_clock(i_reference_clock_input),
      .o_tx_enable(i_mii_tx_enable), .o_tx_data(i_mii_tx_data),
      .o_rmii_tx_enable(i_rmii_tx_enable), .o_rmii_tx_data(i_rmii_tx_data)
   );
   initial
   begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end
   // Recovered line clock, one nibble period of 10 core cycles
   initial
   begin
      i_line_rx_clock = 1'b0;
      #13;
      forever #200 i_line_rx_clock = ~i_line_rx_clock;
   end
   always @(negedge i_clock)
   begin
      if (o_line_tx_valid === 1'b1)
         txq.push_back(o_line_tx_nibble);
      if (o_mii_collision === 1'b1)
         col_seen = 1'b1;
      if (o_rmii_rx_error === 1'b1)
         col_seen = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [3:0] exp, got);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic stop_test;
      $display("Compares %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge i_clock);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask
   // Mode pins are static, so each change goes under reset
   task automatic rst(input logic rm, sp);
      tick(1);
      i_reset_n     = 1'b0;
      i_rmii_mode   = rm;
      i_speed_100   = sp;
      i_full_duplex = 1'b0;
      tick(3);
      i_reset_n = 1'b1;
      tick(4);
   endtask
   task automatic nib(input logic [3:0] d, input logic sfd, err);
      i_line_nibble       = d;
      i_line_sfd          = sfd;
      i_line_code_error   = err;
      i_line_nibble_valid = 1'b1;
      tick(1);
      i_line_sfd          = 1'b0;
      i_line_code_error   = 1'b0;
      i_line_nibble_valid = 1'b0;
      tick(9);
   endtask
   task automatic wait_tx(input int n);
      for (int k = 0; k < 300 && txq.size() < n; k++)
         tick(1);
      tick(30);
      chk("tx count", 4'(n), 4'(txq.size()));
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_mii_tx;
      logic [3:0] e[3] = '{4'h1, 4'h7, 4'hc};
      rst(1'b0, 1'b0);
      txq.delete();
      i_mac.mii_send('{4'h1, 4'h7, 4'hc}, 1'b1);
      wait_tx(3);
      foreach (e[i])
         chk("tx nibble", e[i], txq[i]);
   endtask
   // Odd trailing di-bit is dropped when enable falls
   task automatic t_rmii_tx;
      rst(1'b1, 1'b1);
      txq.delete();
      i_mac.rmii_send('{2'h1, 2'h2, 2'h3, 2'h0, 2'h2}, 1'b1);
      wait_tx(2);
      chk("di-bit pair", 4'h9, txq[0]);
      chk("di-bit pair", 4'h3, txq[1]);
   endtask
   task automatic t_rx(input logic sp);
      logic [3:0] e[$] = '{4'hd, 4'ha, 4'h3};
      rst(1'b0, sp);
      i_mac.rxq.delete();
      i_mac.errq.delete();
      if (sp)
         pulse(i_line_start_pair);
      else
         pulse(i_line_preamble_ok);
      chk("carrier up", 4'h1, {3'h0, o_mii_carrier});
      nib(4'h5, 1'b0, 1'b0);
      nib(4'hd, 1'b1, 1'b0);
      nib(4'ha, 1'b0, 1'b1);
      nib(4'h3, 1'b0, 1'b0);
      tick(20);
      if (sp)
         pulse(i_line_end_pair);
      else
         pulse(i_line_eof);
      tick(30);
      chk("carrier down", 4'h0, {3'h0, o_mii_carrier});
      if (sp)
         e.push_front(4'h5);
      chk("rx count", 4'(e.size()), 4'(i_mac.rxq.size()));
      foreach (e[i])
      begin
         chk("rx nibble", e[i], i_mac.rxq[i]);
         chk("rx error", {3'h0, e[i] == 4'ha}, {3'h0, i_mac.errq[i]});
      end
   endtask
   task automatic t_coll(input logic fd);
      rst(1'b0, 1'b1);
      i_full_duplex = fd;
      col_seen      = 1'b0;
      pulse(i_line_start_pair);
      i_mac.mii_send('{4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'h5}, 1'b0);
      tick(1);
      pulse(i_line_end_pair);
      tick(10);
      chk("collision", {3'h0, ~fd}, {3'h0, col_seen});
   endtask
   task automatic t_rrx;
      logic [1:0] q[$];
      logic [1:0] e[4] = '{2'h2, 2'h3, 2'h2, 2'h1};
      rst(1'b1, 1'b1);
      col_seen = 1'b0;
      pulse(i_line_zero_pair);
      chk("crs_dv up", 4'h1, {3'h0, o_rmii_crs_dv});
      chk("rxd idle", 4'h0, {2'h0, o_rmii_rx_data});
      i_mac.dbq.delete();
      nib(4'he, 1'b0, 1'b0);
      nib(4'h6, 1'b0, 1'b1);
      tick(20);
      pulse(i_line_end_pair);
      tick(40);
      chk("crs_dv down", 4'h0, {3'h0, o_rmii_crs_dv});
      chk("rx_er", 4'h1, {3'h0, col_seen});
      q = i_mac.dbq;
      while (q.size() > 0 && q[0] == 2'h0)
         void'(q.pop_front());
      foreach (e[i])
         chk("rx di-bit", {2'h0, e[i]}, {2'h0, q[i]});
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      err_total           = 0;
      tests_run           = 0;
      col_seen            = 1'b0;
      i_reset_n           = 1'b0;
      i_rmii_mode         = 1'b0;
      i_speed_100         = 1'b0;
      i_full_duplex       = 1'b0;
      i_link_up           = 1'b1;
      i_line_nibble       = 4'h0;
      i_line_nibble_valid = 1'b0;
      i_line_sfd          = 1'b0;
      i_line_code_error   = 1'b0;
      i_line_preamble_ok  = 1'b0;
      i_line_start_pair   = 1'b0;
      i_line_end_pair     = 1'b0;
      i_line_eof          = 1'b0;
      i_line_zero_pair    = 1'b0;
      t_mii_tx;
      t_rmii_tx;
      t_rx(1'b0);
      t_rx(1'b1);
      t_coll(1'b0);
      t_coll(1'b1);
      t_rrx;
      stop_test;
   end
   // Cuts a hung clock wait short
   initial
   begin
      #2000000;
      err_total++;
      $display("[FAIL] run time expected done seen hung");
      stop_test;
   end
endmodule
